//--- rtl/qcr_consts.svh
/*
  Register offsets, field positions, reset values and codes of the
  quadrature counting and reset-synchronized PWM timer slice.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef QCR_CONSTS_SVH
`define QCR_CONSTS_SVH

// Byte offsets on the register bus, one aligned word each.
`define QCR_OFF_START 8'h00
`define QCR_OFF_CH3_MODE 8'h04
`define QCR_OFF_CH3_CTRL 8'h08
`define QCR_OFF_CHAN_CFG 8'h0C
`define QCR_OFF_OUT_CTRL 8'h10
`define QCR_OFF_OUT_EN 8'h14
`define QCR_OFF_GATE_CTRL 8'h18
`define QCR_OFF_CH3_CNT 8'h1C
`define QCR_OFF_CH4_CNT 8'h20
`define QCR_OFF_CH3_PERIOD 8'h24
`define QCR_OFF_PAIR1 8'h28
`define QCR_OFF_PAIR2 8'h2C
`define QCR_OFF_PAIR3 8'h30
`define QCR_OFF_CH0_CNT 8'h34
`define QCR_OFF_CH0_SPEED 8'h38
`define QCR_OFF_CH0_WIDTH 8'h3C
`define QCR_OFF_CH0_POS 8'h40
`define QCR_OFF_CH0_BUF 8'h44
`define QCR_OFF_CH1_CNT 8'h48
`define QCR_OFF_CH1_CAPA 8'h4C
`define QCR_OFF_CH1_CAPB 8'h50
`define QCR_OFF_CH2_CNT 8'h54
`define QCR_OFF_STATUS 8'h58

// Run bits of the start register.
`define QCR_RUN_CH0 0
`define QCR_RUN_CH1 1
`define QCR_RUN_CH2 2
`define QCR_RUN_CH3 3
`define QCR_RUN_CH4 4

// Channel configuration register fields.
`define QCR_CFG_QUAD1 0
`define QCR_CFG_QUAD2 1
`define QCR_CFG_WIDTH_CAP 2
`define QCR_CFG_POS_CAP 3
`define QCR_CFG_PSC_LSB 4

// Channel 3 control register fields.
`define QCR_CTRL_PSC_LSB 0
`define QCR_CTRL_EDGE_LSB 3
`define QCR_CTRL_CLR_LSB 5

// Output control register fields.
`define QCR_OC_TOG_EN 0
`define QCR_OC_NEG_LVL 1
`define QCR_OC_POS_LVL 2

// Gate control register fields.
`define QCR_GC_BDC 0
`define QCR_GC_FB_SEL 1
`define QCR_GC_DIRECT 2
`define QCR_GC_PAT_LSB 3

// Per-channel status nibble fields.
`define QCR_ST_OVF 0
`define QCR_ST_UNF 1
`define QCR_ST_DIR 2

// Codes and reset values.
`define QCR_MODE_RSPWM 4'h8
`define QCR_CLR_PERIOD 3'h1
`define QCR_EDGE_RISE 2'h0
`define QCR_EDGE_FALL 2'h1
`define QCR_RST_PERIOD 16'hFFFF
`define QCR_RST_STATUS 4'h4
`define QCR_CNT_ONE 16'h0001

`endif

//--- rtl/qcr_pkg.sv
/*
  Types shared by the timer slice: bus carriers, pin bundle, bus state
  and the software-visible register image.
  Assumes the constants header sits beside it.
*/
`default_nettype none

package qcr_pkg;
  `include "qcr_consts.svh"

  typedef logic [15:0] qcr_cnt_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } qcr_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } qcr_avs_rsp_t;

  typedef struct packed {
    logic cycle_toggle_out;
    logic pwm_out3_neg;
    logic pwm_out2_neg;
    logic pwm_out1_neg;
    logic pwm_out3_pos;
    logic pwm_out2_pos;
    logic pwm_out1_pos;
  } qcr_pwm_pins_t;

  typedef enum logic [1:0] {
    QCR_BUS_IDLE = 2'b01,
    QCR_BUS_ACK = 2'b10
  } qcr_bus_state_t;

  typedef struct packed {
    logic [4:0] start;
    logic [3:0] ch3_mode;
    logic [7:0] ch3_ctrl;
    logic [6:0] chan_cfg;
    logic [2:0] out_ctrl;
    logic [5:0] out_en;
    logic [8:0] gate_ctrl;
    qcr_cnt_t ch3_counter;
    qcr_cnt_t ch4_counter;
    qcr_cnt_t ch3_period_reg;
    qcr_cnt_t pair1_transition_reg;
    qcr_cnt_t pair2_transition_reg;
    qcr_cnt_t pair3_transition_reg;
    qcr_cnt_t ch0_cnt;
    qcr_cnt_t ch0_speed_period_reg;
    qcr_cnt_t ch0_width_capture_reg;
    qcr_cnt_t ch0_position_period_reg;
    qcr_cnt_t ch0_capture_buffer_reg;
    qcr_cnt_t [1:0] qcnt;
    qcr_cnt_t ch1_capture_a_reg;
    qcr_cnt_t ch1_capture_b_reg;
    logic [1:0][3:0] status;
    logic [2:0] pwm_state;
    logic cyc_tog;
  } qcr_regs_t;
endpackage : qcr_pkg

`default_nettype wire

//--- rtl/qcr_quad_dec.sv
/*
  Two-phase decoder for quadrature variant 4 of one channel.
  Assumes phase inputs are synchronous to clk_sys.
*/
`default_nettype none

module qcr_quad_dec (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic enable,
  input wire logic phase_a,
  input wire logic phase_b,
  output logic count_up,
  output logic count_dn
);
  import qcr_pkg::*;

  logic a_q;
  logic b_q;
  logic b_edge;
  logic a_steady;

  // Only a B edge under a steady A counts; A edges alone never count.
  assign b_edge = phase_b != b_q;
  assign a_steady = phase_a == a_q;
  // B rising with A high or falling with A low means up, else down.
  assign count_up = enable && b_edge && a_steady
                    && (phase_b == phase_a);
  assign count_dn = enable && b_edge && a_steady
                    && (phase_b != phase_a);

  // Previous phase levels for edge detection.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= phase_a;
      b_q <= phase_b;
    end
  end
endmodule : qcr_quad_dec

`default_nettype wire

//--- rtl/qcr_top.sv
/*
  Timer slice: quadrature variant 4 counting on channels 1 and 2, the
  channel 0 to channel 1 capture links, and reset-synchronized
  three-phase PWM on channels 3 and 4, behind an Avalon-MM slave.
  Assumes all pin inputs are synchronous to clk_sys and srst is
  synchronous, active high.
*/
`default_nettype none
`include "qcr_consts.svh"

module qcr_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire qcr_pkg::qcr_avs_req_t avs,
  output qcr_pkg::qcr_avs_rsp_t avs_rsp,
  input wire logic ch1_phase_a_in,
  input wire logic ch1_phase_b_in,
  input wire logic ch2_phase_a_in,
  input wire logic ch2_phase_b_in,
  input wire logic ext_clk_in,
  input wire logic [2:0] fb_in,
  output qcr_pkg::qcr_pwm_pins_t pins,
  output logic [6:0] pins_oe
);
  import qcr_pkg::*;

  qcr_regs_t r;
  qcr_regs_t next_r;
  qcr_bus_state_t bus_state;
  qcr_bus_state_t next_bus_state;
  qcr_avs_rsp_t next_rsp;
  qcr_pwm_pins_t next_pins;
  logic [6:0] next_pins_oe;
  logic [5:0] presc;
  logic [5:0] next_presc;
  logic ext_q;
  logic [1:0] q_up;
  logic [1:0] q_dn;
  logic [1:0] phase_a;
  logic [1:0] phase_b;
  logic wr_fire;
  logic pwm_mode;

  // Reset image of the register set.
  function automatic qcr_regs_t rst_regs();
    qcr_regs_t v;
    v = '0;
    v.ch3_period_reg = `QCR_RST_PERIOD;
    v.status = {`QCR_RST_STATUS, `QCR_RST_STATUS};
    rst_regs = v;
  endfunction : rst_regs

  // Count tick from the prescaler or from the external clock edge.
  function automatic logic presc_tick(input logic [2:0] sel,
      input logic [5:0] pc, input logic ext_edge);
    case (sel)
      3'h0: presc_tick = 1'b1;
      3'h1: presc_tick = &pc[1:0];
      3'h2: presc_tick = &pc[3:0];
      3'h3: presc_tick = &pc[5:0];
      default: presc_tick = ext_edge;
    endcase
  endfunction : presc_tick

  // Merges write data into a register under the two low byte enables.
  function automatic logic [15:0] wrv(input logic [15:0] old);
    wrv = {avs.byteenable[1] ? avs.writedata[15:8] : old[15:8],
           avs.byteenable[0] ? avs.writedata[7:0] : old[7:0]};
  endfunction : wrv

  // Read decode; unmapped offsets read as zero.
  function automatic logic [31:0] rd(input logic [7:0] a,
      input qcr_regs_t v);
    case (a)
      `QCR_OFF_START: rd = 32'(v.start);
      `QCR_OFF_CH3_MODE: rd = 32'(v.ch3_mode);
      `QCR_OFF_CH3_CTRL: rd = 32'(v.ch3_ctrl);
      `QCR_OFF_CHAN_CFG: rd = 32'(v.chan_cfg);
      `QCR_OFF_OUT_CTRL: rd = 32'(v.out_ctrl);
      `QCR_OFF_OUT_EN: rd = 32'(v.out_en);
      `QCR_OFF_GATE_CTRL: rd = 32'(v.gate_ctrl);
      `QCR_OFF_CH3_CNT: rd = 32'(v.ch3_counter);
      `QCR_OFF_CH4_CNT: rd = 32'(v.ch4_counter);
      `QCR_OFF_CH3_PERIOD: rd = 32'(v.ch3_period_reg);
      `QCR_OFF_PAIR1: rd = 32'(v.pair1_transition_reg);
      `QCR_OFF_PAIR2: rd = 32'(v.pair2_transition_reg);
      `QCR_OFF_PAIR3: rd = 32'(v.pair3_transition_reg);
      `QCR_OFF_CH0_CNT: rd = 32'(v.ch0_cnt);
      `QCR_OFF_CH0_SPEED: rd = 32'(v.ch0_speed_period_reg);
      `QCR_OFF_CH0_WIDTH: rd = 32'(v.ch0_width_capture_reg);
      `QCR_OFF_CH0_POS: rd = 32'(v.ch0_position_period_reg);
      `QCR_OFF_CH0_BUF: rd = 32'(v.ch0_capture_buffer_reg);
      `QCR_OFF_CH1_CNT: rd = 32'(v.qcnt[0]);
      `QCR_OFF_CH1_CAPA: rd = 32'(v.ch1_capture_a_reg);
      `QCR_OFF_CH1_CAPB: rd = 32'(v.ch1_capture_b_reg);
      `QCR_OFF_CH2_CNT: rd = 32'(v.qcnt[1]);
      `QCR_OFF_STATUS: rd = 32'(v.status);
      default: rd = 32'h0000_0000;
    endcase
  endfunction : rd

  // Phase pins per quadrature channel: A/B on 1, C/D on 2.
  assign phase_a = {ch2_phase_a_in, ch1_phase_a_in};
  assign phase_b = {ch2_phase_b_in, ch1_phase_b_in};
  assign pwm_mode = r.ch3_mode == `QCR_MODE_RSPWM;
  assign wr_fire = bus_state == QCR_BUS_ACK && avs.write;

  // One variant 4 decoder per quadrature channel.
  for (genvar g = 0; g < 2; g++) begin : gen_dec
    qcr_quad_dec u_dec (
      .clk_sys(clk_sys),
      .srst(srst),
      .enable(r.chan_cfg[`QCR_CFG_QUAD1 + g] && r.start[`QCR_RUN_CH1 + g]),
      .phase_a(phase_a[g]),
      .phase_b(phase_b[g]),
      .count_up(q_up[g]),
      .count_dn(q_dn[g])
    );
  end

  // Bus slave: one wait state, then waitrequest low for one cycle.
  always_comb begin
    next_bus_state = bus_state;
    next_rsp = avs_rsp;
    unique case (bus_state)
      QCR_BUS_IDLE: begin
        if (avs.read || avs.write) begin
          next_bus_state = QCR_BUS_ACK;
          next_rsp.waitrequest = 1'b0;
          next_rsp.readdata = avs.read ? rd(avs.address, r) : '0;
        end
      end
      QCR_BUS_ACK: begin
        next_bus_state = QCR_BUS_IDLE;
        next_rsp.waitrequest = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_state <= QCR_BUS_IDLE;
      avs_rsp <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
    end else begin
      bus_state <= next_bus_state;
      avs_rsp <= next_rsp;
    end
  end

  // Counters, captures, PWM state, software writes and status flags.
  always_comb begin
    logic ext_edge;
    logic tick0;
    logic tick3;
    logic run0;
    logic cmp_a;
    logic cmp_c;
    logic clr3;
    logic width_clk;
    logic [2:0] tog;
    logic [1:0] up;
    logic [1:0] dn;
    logic [1:0] ovf;
    logic [1:0] unf;
    logic [1:0] step;
    logic [1:0] edge_sel;
    next_r = r;
    next_presc = presc + 6'h01;
    edge_sel = r.ch3_ctrl[`QCR_CTRL_EDGE_LSB +: 2];
    ext_edge = (ext_clk_in && !ext_q && edge_sel != `QCR_EDGE_FALL)
               || (!ext_clk_in && ext_q && edge_sel != `QCR_EDGE_RISE);
    tick0 = presc_tick(r.chan_cfg[`QCR_CFG_PSC_LSB +: 3], presc, ext_edge);
    tick3 = presc_tick(r.ch3_ctrl[`QCR_CTRL_PSC_LSB +: 3], presc, ext_edge);
    run0 = tick0 && r.start[`QCR_RUN_CH0];
    ovf = '0;
    unf = '0;
    // Channel 0 frames the control periods by its two compare matches.
    cmp_a = run0 && r.ch0_cnt == r.ch0_speed_period_reg;
    cmp_c = run0 && r.ch0_cnt == r.ch0_position_period_reg;
    if (run0) begin
      next_r.ch0_cnt = cmp_c ? '0 : r.ch0_cnt + `QCR_CNT_ONE;
    end
    // Quadrature channels ignore the prescaler; plain mode uses it.
    for (int i = 0; i < 2; i++) begin
      step[i] = tick0 && r.start[`QCR_RUN_CH1 + i];
      up[i] = r.chan_cfg[`QCR_CFG_QUAD1 + i] ? q_up[i] : step[i];
      dn[i] = r.chan_cfg[`QCR_CFG_QUAD1 + i] && q_dn[i];
      if (up[i]) begin
        next_r.qcnt[i] = r.qcnt[i] + `QCR_CNT_ONE;
        ovf[i] = r.qcnt[i] == `QCR_RST_PERIOD;
        next_r.status[i][`QCR_ST_DIR] = 1'b1;
      end else if (dn[i]) begin
        next_r.qcnt[i] = r.qcnt[i] - `QCR_CNT_ONE;
        unf[i] = r.qcnt[i] == '0;
        next_r.status[i][`QCR_ST_DIR] = 1'b0;
      end
    end
    // Channel 1 count clock latches the width, old width into buffer.
    width_clk = up[0] || dn[0];
    if (r.chan_cfg[`QCR_CFG_WIDTH_CAP] && width_clk) begin
      next_r.ch0_capture_buffer_reg = r.ch0_width_capture_reg;
      next_r.ch0_width_capture_reg = r.ch0_cnt;
    end
    // Channel 0 matches latch the channel 1 position count.
    if (r.chan_cfg[`QCR_CFG_POS_CAP]) begin
      if (cmp_a) begin
        next_r.ch1_capture_a_reg = r.qcnt[0];
      end
      if (cmp_c) begin
        next_r.ch1_capture_b_reg = r.qcnt[0];
      end
    end
    // Channel 3 up-counter bounded by the period register.
    clr3 = 1'b0;
    tog = '0;
    if (tick3 && r.start[`QCR_RUN_CH3]) begin
      clr3 = r.ch3_counter == r.ch3_period_reg
             && r.ch3_ctrl[`QCR_CTRL_CLR_LSB +: 3] == `QCR_CLR_PERIOD;
      next_r.ch3_counter = clr3 ? '0
                           : r.ch3_counter + `QCR_CNT_ONE;
      if (pwm_mode) begin
        next_r.ch4_counter = clr3 ? '0 : r.ch4_counter + `QCR_CNT_ONE;
        tog = {r.ch3_counter == r.pair3_transition_reg,
               r.ch3_counter == r.pair2_transition_reg,
               r.ch3_counter == r.pair1_transition_reg};
        tog = tog | {3{clr3}};
        next_r.pwm_state = r.pwm_state ^ tog;
        if (clr3 && r.out_ctrl[`QCR_OC_TOG_EN]) begin
          next_r.cyc_tog = ~r.cyc_tog;
        end
      end
    end
    if (!pwm_mode && tick3 && r.start[`QCR_RUN_CH4]) begin
      next_r.ch4_counter = r.ch4_counter + `QCR_CNT_ONE;
    end
    // Software writes win over counting in the same cycle.
    if (wr_fire) begin
      case (avs.address)
        `QCR_OFF_START: next_r.start = 5'(wrv(16'(r.start)));
        `QCR_OFF_CH3_MODE: next_r.ch3_mode = 4'(wrv(16'(r.ch3_mode)));
        `QCR_OFF_CH3_CTRL: next_r.ch3_ctrl = 8'(wrv(16'(r.ch3_ctrl)));
        `QCR_OFF_CHAN_CFG: next_r.chan_cfg = 7'(wrv(16'(r.chan_cfg)));
        `QCR_OFF_OUT_CTRL: next_r.out_ctrl = 3'(wrv(16'(r.out_ctrl)));
        `QCR_OFF_OUT_EN: next_r.out_en = 6'(wrv(16'(r.out_en)));
        `QCR_OFF_GATE_CTRL: next_r.gate_ctrl = 9'(wrv(16'(r.gate_ctrl)));
        `QCR_OFF_CH3_CNT: next_r.ch3_counter = wrv(r.ch3_counter);
        `QCR_OFF_CH4_CNT: next_r.ch4_counter = wrv(r.ch4_counter);
        `QCR_OFF_CH3_PERIOD: next_r.ch3_period_reg = wrv(r.ch3_period_reg);
        `QCR_OFF_PAIR1:
          next_r.pair1_transition_reg = wrv(r.pair1_transition_reg);
        `QCR_OFF_PAIR2:
          next_r.pair2_transition_reg = wrv(r.pair2_transition_reg);
        `QCR_OFF_PAIR3:
          next_r.pair3_transition_reg = wrv(r.pair3_transition_reg);
        `QCR_OFF_CH0_CNT: next_r.ch0_cnt = wrv(r.ch0_cnt);
        `QCR_OFF_CH0_SPEED:
          next_r.ch0_speed_period_reg = wrv(r.ch0_speed_period_reg);
        `QCR_OFF_CH0_POS:
          next_r.ch0_position_period_reg = wrv(r.ch0_position_period_reg);
        `QCR_OFF_CH1_CNT: next_r.qcnt[0] = wrv(r.qcnt[0]);
        `QCR_OFF_CH2_CNT: next_r.qcnt[1] = wrv(r.qcnt[1]);
        `QCR_OFF_STATUS: begin
          // Writing one clears a flag; the direction bits are read-only.
          for (int i = 0; i < 2; i++) begin
            next_r.status[i][`QCR_ST_OVF] = r.status[i][`QCR_ST_OVF]
              && !avs.writedata[4 * i + `QCR_ST_OVF];
            next_r.status[i][`QCR_ST_UNF] = r.status[i][`QCR_ST_UNF]
              && !avs.writedata[4 * i + `QCR_ST_UNF];
          end
        end
        default: begin
        end
      endcase
    end
    // Flag events set after any clear so a same-cycle event survives.
    for (int i = 0; i < 2; i++) begin
      if (ovf[i]) begin
        next_r.status[i][`QCR_ST_OVF] = 1'b1;
      end
      if (unf[i]) begin
        next_r.status[i][`QCR_ST_UNF] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r <= rst_regs();
      presc <= 6'h00;
      ext_q <= 1'b0;
    end else begin
      r <= next_r;
      presc <= next_presc;
      ext_q <= ext_clk_in;
    end
  end

  // Pin shaping: complement, motor gating, level, master enable.
  always_comb begin
    logic [2:0] pos;
    logic [2:0] neg;
    logic [5:0] pat;
    logic [5:0] en;
    pos = r.pwm_state;
    neg = ~r.pwm_state;
    pat = r.gate_ctrl[`QCR_GC_FB_SEL] ? {~fb_in, fb_in}
          : r.gate_ctrl[`QCR_GC_PAT_LSB +: 6];
    if (r.gate_ctrl[`QCR_GC_BDC]) begin
      pos = r.gate_ctrl[`QCR_GC_DIRECT] ? pat[2:0] : pat[2:0] & pos;
      neg = r.gate_ctrl[`QCR_GC_DIRECT] ? pat[5:3] : pat[5:3] & neg;
    end
    pos = r.out_ctrl[`QCR_OC_POS_LVL] ? pos : ~pos;
    neg = r.out_ctrl[`QCR_OC_NEG_LVL] ? neg : ~neg;
    en = pwm_mode ? r.out_en : 6'h00;
    next_pins.pwm_out1_pos = en[0] && pos[0];
    next_pins.pwm_out2_pos = en[1] && pos[1];
    next_pins.pwm_out3_pos = en[2] && pos[2];
    next_pins.pwm_out1_neg = en[3] && neg[0];
    next_pins.pwm_out2_neg = en[4] && neg[1];
    next_pins.pwm_out3_neg = en[5] && neg[2];
    next_pins_oe[6] = pwm_mode && r.out_ctrl[`QCR_OC_TOG_EN];
    next_pins.cycle_toggle_out = next_pins_oe[6] && r.cyc_tog;
    next_pins_oe[5:0] = en;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pins <= '0;
      pins_oe <= 7'h00;
    end else begin
      pins <= next_pins;
      pins_oe <= next_pins_oe;
    end
  end
endmodule : qcr_top

`default_nettype wire

//--- sim/qcr_enc_model.sv
/*
  Two-phase encoder model for one A/B pin pair.
  Assumes step requests change just after clk_sys edges.
*/
`default_nettype none

module qcr_enc_model (
  input wire logic clk_sys,
  input wire logic step,
  input wire logic fwd,
  output logic phase_a,
  output logic phase_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pos = 2'h0;

  // Walks 00,10,11,01 forward; one phase moves per step, so each phase
  // holds for at least a clock between its edges.
  always_ff @(posedge clk_sys) begin
    if (step) begin
      pos <= fwd ? pos + 2'h1 : pos - 2'h1;
    end
  end
  assign phase_a = pos[1] ^ pos[0];
  assign phase_b = pos[1];
endmodule : qcr_enc_model

`default_nettype wire

//--- sim/qcr_top_asserts.sv
/*
  Port checker for the timer slice, bound into its top module.
  Assumes the package and the constants header are compiled first.
*/
`default_nettype none
`include "qcr_consts.svh"

module qcr_top_asserts (
  input wire logic clk_sys,
  input wire logic srst,
  input wire qcr_pkg::qcr_avs_req_t avs,
  input wire qcr_pkg::qcr_avs_rsp_t avs_rsp,
  input wire qcr_pkg::qcr_pwm_pins_t pins,
  input wire logic [6:0] pins_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import qcr_pkg::*;
  logic [3:0] mode, next_mode;
  logic [1:0] lvl, next_lvl, quiet, next_quiet;
  logic run, next_run, bdc, next_bdc, calm;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Mirrors completed writes and counts calm cycles since the last one.
  always_comb begin
    next_mode = mode;
    next_lvl = lvl;
    next_run = run;
    next_bdc = bdc;
    next_quiet = (quiet == 2'h3) ? quiet : quiet + 2'h1;
    if (avs.write && !avs_rsp.waitrequest) begin
      next_quiet = 2'h0;
      case (avs.address)
        `QCR_OFF_CH3_MODE: next_mode = avs.writedata[3:0];
        `QCR_OFF_OUT_CTRL: next_lvl = avs.writedata[2:1];
        `QCR_OFF_START: next_run = avs.writedata[3];
        `QCR_OFF_GATE_CTRL: next_bdc = avs.writedata[0];
        default: ;
      endcase
    end
  end

  // Registers the mirror; cleared with the design.
  always_ff @(posedge clk_sys) begin
    {mode, lvl, run, bdc, quiet} <= srst ? 10'h000 :
      {next_mode, next_lvl, next_run, next_bdc, next_quiet};
  end
  assign calm = quiet == 2'h3;

  bus_answer_a: assert property ((avs.read || avs.write) &&
    avs_rsp.waitrequest |=> !avs_rsp.waitrequest)
    else $error("bus request not answered next cycle");
  ack_single_a: assert property (!avs_rsp.waitrequest |=>
    avs_rsp.waitrequest) else $error("bus answer longer than one cycle");
  bus_idle_a: assert property (!(avs.read || avs.write) &&
    avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("bus answer without request");
  unmapped_zero_a: assert property (avs.read && avs.address == 8'hFC &&
    avs_rsp.waitrequest |=> avs_rsp.readdata == 32'h0)
    else $error("unmapped read not zero");
  pwm_off_a: assert property (
    calm && mode != `QCR_MODE_RSPWM |-> pins == 7'h00 && pins_oe == 7'h00)
    else $error("pins active outside pwm mode");
  disabled_low_a: assert property (
    (pins[5:0] & ~pins_oe[5:0]) == 6'h00)
    else $error("disabled pin not low");
  pair_comp_a: assert property (
    calm && mode == `QCR_MODE_RSPWM && !bdc && lvl[0] == lvl[1] &&
    pins_oe[5:0] == 6'h3F |-> pins[5:3] == ~pins[2:0])
    else $error("negative pin not complement of positive");
  halted_hold_a: assert property (
    calm && !run && !bdc |=> $stable(pins))
    else $error("pins moved while channel 3 halted");
endmodule : qcr_top_asserts

bind qcr_top qcr_top_asserts i_asserts (.clk_sys(clk_sys), .srst(srst),
  .avs(avs), .avs_rsp(avs_rsp), .pins(pins), .pins_oe(pins_oe));

`default_nettype wire

//--- sim/test_quadrature_count_and_reset_sync_pwm.sv
/*
  Self-checking bench: encoder counting, capture links and
  reset-synchronized PWM through the register bus.
  Assumes design, package, checker and encoder model compile first.
*/
`default_nettype none
`include "qcr_consts.svh"

module test_quadrature_count_and_reset_sync_pwm;
  timeunit 1ns;
  timeprecision 1ns;
  import qcr_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  qcr_avs_req_t avs = '0;
  qcr_avs_rsp_t avs_rsp;
  qcr_pwm_pins_t pins;
  logic [6:0] pins_oe, last;
  logic [1:0] step = 2'h0, fwd = 2'h0, pa, pb, la = 2'h0, lb = 2'h0;
  logic [1:0] dir = 2'h3, unf = 2'h0, ovf = 2'h0;
  logic [3:0] noise = 4'h0;
  logic [31:0] rdat;
  qcr_cnt_t expq [2] = '{16'h0000, 16'h0000};
  qcr_cnt_t dl, per, t3;
  int failures = 0, checked = 0;
  int tg [5];

  qcr_top i_dut (.clk_sys(clk_sys), .srst(srst), .avs(avs),
    .avs_rsp(avs_rsp), .ch1_phase_a_in(pa[0]), .ch1_phase_b_in(pb[0]),
    .ch2_phase_a_in(pa[1]), .ch2_phase_b_in(pb[1]),
    .ext_clk_in(noise[3]), .fb_in(noise[2:0]), .pins(pins),
    .pins_oe(pins_oe));
  qcr_enc_model i_enc1 (.clk_sys(clk_sys), .step(step[0]),
    .fwd(fwd[0]), .phase_a(pa[0]), .phase_b(pb[0]));
  qcr_enc_model i_enc2 (.clk_sys(clk_sys), .step(step[1]),
    .fwd(fwd[1]), .phase_a(pa[1]), .phase_b(pb[1]));

  // Clock, noise on unused inputs and the hang guard.
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) noise <= 4'($urandom);
  initial begin
    #400000;
    failures++;
    conclude();
  end

  // Count step for one pin change: B edges with A steady only.
  function automatic qcr_cnt_t dq(input logic a0, b0, a1, b1);
    if (a0 != a1 || b0 == b1) return 16'h0000;
    return (a1 == b1) ? 16'h0001 : 16'hFFFF;
  endfunction : dq

  // Predicts count, direction and wrap flags of both channels.
  always @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      dl = dq(la[i], lb[i], pa[i], pb[i]);
      if (dl == 16'hFFFF && expq[i] == 16'h0000) unf[i] = 1'b1;
      if (dl == 16'h0001 && expq[i] == 16'hFFFF) ovf[i] = 1'b1;
      if (dl != 16'h0000) dir[i] = (dl == 16'h0001);
      expq[i] = expq[i] + dl;
    end
    la = pa;
    lb = pb;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One transfer, held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    avs <= '{read: !wr, write: wr, address: a, writedata: d,
      byteenable: 4'hF};
    // Only the watchdog ends a wait that never sees an answer.
    do begin
      @(posedge clk_sys);
    end while (avs_rsp.waitrequest !== 1'b0);
    rdat = avs_rsp.readdata;
    avs <= '0;
  endtask : bus

  // Steps encoder 1 forward until its count has moved once.
  task automatic one_count();
    qcr_cnt_t s;
    s = expq[0];
    fwd <= 2'h3;
    while (expq[0] == s) begin
      step <= 2'h1;
      @(posedge clk_sys);
      step <= 2'h0;
      repeat (2) @(posedge clk_sys);
    end
  endtask : one_count

  task automatic rdc(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask : rdc

  task automatic conclude();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    void'($urandom(32'h5d77_8743));
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    rdc("period reset", `QCR_OFF_CH3_PERIOD, 32'h0000_FFFF);
    rdc("status reset", `QCR_OFF_STATUS, 32'h44);
    rdc("unmapped read", 8'hFC, 32'h0);
    $display("reset test done");
    // Encoder walk: down first, through zero, then random.
    bus(1'b1, `QCR_OFF_CHAN_CFG, 32'h3);
    bus(1'b1, `QCR_OFF_START, 32'h6);
    for (int i = 0; i < 200; i++) begin
      step <= 2'($urandom);
      fwd <= (i < 60) ? 2'h0 : 2'($urandom);
      @(posedge clk_sys);
      step <= 2'h0;
      @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    rdc("ch1 count", `QCR_OFF_CH1_CNT, {16'h0, expq[0]});
    rdc("ch2 count", `QCR_OFF_CH2_CNT, {16'h0, expq[1]});
    rdc("status", `QCR_OFF_STATUS, {25'h0, dir[1], unf[1], ovf[1], 1'b0,
      dir[0], unf[0], ovf[0]});
    $display("quadrature test done");
    // Channel 0 compares latch the still channel 1 count.
    bus(1'b1, `QCR_OFF_CH0_SPEED, 32'h3);
    bus(1'b1, `QCR_OFF_CH0_POS, 32'h7);
    bus(1'b1, `QCR_OFF_CHAN_CFG, 32'hF);
    bus(1'b1, `QCR_OFF_START, 32'h1);
    repeat (20) @(posedge clk_sys);
    bus(1'b1, `QCR_OFF_CH1_CAPA, 32'h5A5A);
    rdc("capture a", `QCR_OFF_CH1_CAPA, {16'h0, expq[0]});
    rdc("capture b", `QCR_OFF_CH1_CAPB, {16'h0, expq[0]});
    // Each channel 1 count latches channel 0, the older value buffered.
    bus(1'b1, `QCR_OFF_START, 32'h3);
    one_count();
    bus(1'b0, `QCR_OFF_CH0_WIDTH, 32'h0);
    per = rdat[15:0];
    one_count();
    rdc("width buffer", `QCR_OFF_CH0_BUF, {16'h0, per});
    $display("capture test done");
    // Halted setup of reset-synchronized PWM, then start.
    per = 16'($urandom_range(12, 4));
    t3 = 16'($urandom_range(per - 1, 1));
    bus(1'b1, `QCR_OFF_START, 32'h0);
    bus(1'b1, `QCR_OFF_CH3_CTRL, 32'h20);
    bus(1'b1, `QCR_OFF_CH3_CNT, 32'h0);
    bus(1'b1, `QCR_OFF_CH4_CNT, 32'h0);
    bus(1'b1, `QCR_OFF_CH3_PERIOD, {16'h0, per});
    bus(1'b1, `QCR_OFF_PAIR1, {16'h0, per});
    bus(1'b1, `QCR_OFF_PAIR2, 32'h0);
    bus(1'b1, `QCR_OFF_PAIR3, {16'h0, t3});
    bus(1'b1, `QCR_OFF_OUT_CTRL, 32'h7);
    bus(1'b1, `QCR_OFF_CH3_MODE, 32'h8);
    bus(1'b1, `QCR_OFF_OUT_EN, 32'h3F);
    bus(1'b1, `QCR_OFF_START, 32'h8);
    repeat (2 * per + 8) @(posedge clk_sys);
    // Toggles over exactly eight periods, any starting phase.
    tg = '{0, 0, 0, 0, 0};
    last = pins;
    repeat (8 * (per + 1)) begin
      @(posedge clk_sys);
      for (int k = 0; k < 3; k++) tg[k] += int'(pins[k] != last[k]);
      tg[3] += int'(pins[2:0] == ~last[2:0]);
      tg[4] += int'(pins[6] != last[6]);
      last = pins;
    end
    chk("pair1 toggles", 32'h8, 32'(tg[0]));
    chk("pair2 toggles", 32'h10, 32'(tg[1]));
    chk("pair3 toggles", 32'h10, 32'(tg[2]));
    chk("shared points", 32'h8, 32'(tg[3]));
    chk("cycle toggles", 32'h8, 32'(tg[4]));
    chk("pin enables", 32'h7F, {25'h0, pins_oe});
    chk("pair1 neg", {31'h0, ~pins.pwm_out1_pos},
      {31'h0, pins.pwm_out1_neg});
    // Direct gate output puts the pattern on the pins as it stands.
    t3 = 16'($urandom_range(63, 0));
    bus(1'b1, `QCR_OFF_GATE_CTRL, {23'h0, t3[5:0], 3'h5});
    repeat (4) @(posedge clk_sys);
    chk("direct gates", {26'h0, t3[5:0]},
      {26'h0, pins[5:0]});
    bus(1'b1, `QCR_OFF_GATE_CTRL, 32'h0);
    bus(1'b1, `QCR_OFF_OUT_CTRL, 32'h3);
    repeat (4) @(posedge clk_sys);
    chk("inverted pos", {31'h0, pins.pwm_out2_neg},
      {31'h0, pins.pwm_out2_pos});
    bus(1'b1, `QCR_OFF_CH3_MODE, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk("pins off", 32'h0, {18'h0, pins, pins_oe});
    $display("pwm test done");
    conclude();
  end
endmodule : test_quadrature_count_and_reset_sync_pwm

`default_nettype wire
